// File: inc/sbrf_pkg.sv
// Purpose: Shared constants and types of the serial bit rate and format block
// Assumes: 8-bit register port, one 250 MHz system clock
// Notes: Register offsets are word indices on the plain register port
package sbrf_pkg;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_DIV = 3'h1;
    localparam logic [2:0] OFS_FMT = 3'h2;
    localparam logic [2:0] OFS_STAT = 3'h3;

    // ==========================================================
    // Mode control fields
    localparam int CTRL_CKS_LO = 0;
    localparam int CTRL_CKS_HI = 1;
    localparam int CTRL_RUN = 5;
    localparam int CTRL_PHALF = 6;
    localparam int CTRL_SYNC = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hE3;

    // Divisor and format register
    localparam logic [7:0] DIV_RST = 8'hFF;
    localparam logic [7:0] FMT_RST = 8'hF2;
    localparam logic [7:0] FMT_ONES = 8'hF2;
    localparam logic [7:0] FMT_WMASK = 8'h0D;
    localparam int FMT_MODE = 0;
    localparam int FMT_INV = 2;
    localparam int FMT_ORDER = 3;

    // Status fields
    localparam int STAT_RUN = 0;
    localparam int STAT_MAXRATE = 1;
    localparam int STAT_SKID = 2;
    localparam int STAT_TXVAL = 3;
    localparam int STAT_SYNC = 4;

    // ==========================================================
    // Timing: prescale masks give periods of 4, 16 and 64 clocks
    localparam logic [5:0] PRE_MASK1 = 6'h03;
    localparam logic [5:0] PRE_MASK2 = 6'h0F;
    localparam logic [5:0] PRE_MASK3 = 6'h3F;
    // Divider ticks per bit: async 32 (64 x 2^(2n-1)), sync 8
    localparam logic [4:0] PH_ASYNC_LAST = 5'h1F;
    localparam logic [4:0] PH_SYNC_LAST = 5'h07;
    // Centre of a bit: eighth cycle of the async 16x serial clock, fourth sync tick
    localparam logic [4:0] PH_ASYNC_MID = 5'h0F;
    localparam logic [4:0] PH_SYNC_MID = 5'h03;

    // ==========================================================
    // Types
    typedef struct packed {
        logic bit_tick;
        logic sample_tick;
        logic mid_tick;
        logic serial_clk;
    } sbrf_tick_type;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] divisor;
        logic [2:0] fmt;
        logic [1:0] act_cks;
        logic act_sync;
        logic [7:0] act_div;
        logic phalf_tog;
        logic [5:0] pre_cnt;
        logic [7:0] div_cnt;
        logic [4:0] phase;
        sbrf_tick_type ticks;
        logic [7:0] rdata;
        logic [7:0] tx_data;
        logic tx_valid;
        logic [7:0] skid_data;
        logic skid_valid;
        logic tx_ready;
        logic [7:0] rx_data;
        logic rx_valid;
    } sbrf_state_type;

endpackage : sbrf_pkg

// File: logic/sbrf_core.sv
// Purpose: Bit rate generator and data format stage of a serial channel
// Assumes: Register port and data ports share sys_clk; standby comes
//          from the power controller on the same clock
// Notes: Framing, parity, error flags and the shift register live
//        elsewhere; this block supplies their ticks and data words
//
// Functional notes
// - Async rate F/(64*2^(2n-1)*(N+1))
// - Sync rate F/(8*2^(2n)*(N+1))
// - Prescale picks clock, /4, /16, /64
// - n zero uses system clock, else peripheral
// - Half peripheral clock halves prescaled rates
// - Sync N=0 n=0 too fast for continuous
// - Format register resets to 0xF2, also standby
// - Format bits 7..4 and 1 read one
// - Bit order select: LSB or MSB first
// - Invert selects data inversion, never parity
// - Divisor readable, resets 0xFF, also standby
// - Async 16x serial clock, sample eighth cycle
`timescale 1ns/100ps

module sbrf_core
    import sbrf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic standby,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Rate ticks towards the shifter
    output logic bit_tick,
    output logic sample_tick,
    output logic mid_tick,
    output logic serial_clk,
    output logic sync_mode,
    // Transmit words in
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    // Formatted transmit words out
    output logic [7:0] tx_out_data,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    // Raw receive words in, formatted words out
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_valid,
    output logic [7:0] rx_out_data,
    output logic rx_out_valid
);

    // ==========================================================
    // State
    sbrf_state_type state_reg;
    sbrf_state_type state_next;

    // Bit order and inversion on eight data bits only
    function automatic logic [7:0] fmt_word(
        input logic [7:0] w,
        input logic msb_first,
        input logic invert
    );
        logic [7:0] r;
        r = w;
        if (msb_first) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = w[7-i];
            end
        end
        // Inversion after the reorder; the two commute anyway
        if (invert) begin
            r = ~r;
        end
        return r;
    endfunction : fmt_word

    // Mask of the prescaler period for the active select
    function automatic logic [5:0] pre_mask(input logic [1:0] cks);
        logic [5:0] m;
        case (cks)
            2'd1: m = PRE_MASK1;
            2'd2: m = PRE_MASK2;
            2'd3: m = PRE_MASK3;
            default: m = 6'h00;
        endcase
        return m;
    endfunction : pre_mask

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic run;
        logic pclk_en;
        logic pre_tick;
        logic div_tick;
        logic [4:0] ph_last;
        logic [4:0] ph_mid;
        logic [7:0] stat;
        logic tx_push;
        logic tx_pop;
        logic [7:0] tx_fmt;
        run = 1'b0;
        pclk_en = 1'b0;
        pre_tick = 1'b0;
        div_tick = 1'b0;
        ph_last = PH_ASYNC_LAST;
        ph_mid = PH_ASYNC_MID;
        stat = 8'h00;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        tx_fmt = 8'h00;
        state_next = state_reg;
        run = state_reg.ctrl[CTRL_RUN];

        // Register writes; reserved format bits are not stored
        if (reg_wr) begin
            case (reg_addr)
                OFS_CTRL: state_next.ctrl = reg_wdata & CTRL_MASK;
                OFS_DIV: state_next.divisor = reg_wdata;
                OFS_FMT: state_next.fmt = {reg_wdata[FMT_ORDER],
                    reg_wdata[FMT_INV], reg_wdata[FMT_MODE]};
                default: state_next.rdata = state_reg.rdata;
            endcase
        end

        // Status view of the generator and data path
        // Status is read only; a write to it lands in the default arm
        stat[STAT_RUN] = run;
        stat[STAT_MAXRATE] = state_reg.act_sync
            && (state_reg.act_cks == 2'd0)
            && (state_reg.act_div == 8'h00);
        stat[STAT_SKID] = state_reg.skid_valid;
        stat[STAT_TXVAL] = state_reg.tx_valid;
        stat[STAT_SYNC] = state_reg.act_sync;

        // Read data stands in the cycle after the strobe only
        state_next.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: state_next.rdata = state_reg.ctrl;
                OFS_DIV: state_next.rdata = state_reg.divisor;
                OFS_FMT: state_next.rdata = FMT_ONES
                    | {4'h0, state_reg.fmt[2], state_reg.fmt[1],
                    1'b0, state_reg.fmt[0]};
                OFS_STAT: state_next.rdata = stat;
                default: state_next.rdata = 8'h00;
            endcase
        end

        // peripheral clock as every or every other cycle
        state_next.phalf_tog = run ? ~state_reg.phalf_tog : 1'b0;
        pclk_en = state_reg.ctrl[CTRL_PHALF] ? state_reg.phalf_tog
            : 1'b1;

        if (state_reg.act_cks == 2'd0) begin
            pre_tick = run;
        end else begin
            pre_tick = run && pclk_en && ((state_reg.pre_cnt
                & pre_mask(state_reg.act_cks))
                == pre_mask(state_reg.act_cks));
        end
        // Free-running count; the reload clears it so a new select
        // always starts on a whole prescaled period
        if (run && pclk_en) begin
            state_next.pre_cnt = state_reg.pre_cnt + 6'd1;
        end

        if (pre_tick) begin
            if (state_reg.div_cnt == 8'h00) begin
                div_tick = 1'b1;
                state_next.act_div = state_reg.divisor;
                state_next.act_cks = state_reg.ctrl[CTRL_CKS_HI:
                    CTRL_CKS_LO];
                state_next.act_sync = state_reg.ctrl[CTRL_SYNC];
                state_next.div_cnt = state_reg.divisor;
                state_next.pre_cnt = 6'h00;
            end else begin
                state_next.div_cnt = state_reg.div_cnt - 8'd1;
            end
        end

        // async bit per 32 divider ticks
        // sync bit per 8 divider ticks
        if (state_reg.act_sync) begin
            ph_last = PH_SYNC_LAST;
            ph_mid = PH_SYNC_MID;
        end
        // A mode change at reload can leave phase past the new end;
        // the >= test closes that bit at once instead of wrapping
        state_next.ticks = '0;
        if (div_tick) begin
            if (state_reg.phase >= ph_last) begin
                state_next.phase = 5'h00;
                state_next.ticks.bit_tick = 1'b1;
            end else begin
                state_next.phase = state_reg.phase + 5'd1;
            end
            state_next.ticks.sample_tick = state_reg.act_sync
                || state_reg.phase[0];
            state_next.ticks.mid_tick = (state_reg.phase == ph_mid);
        end
        // Serial clock high in the second half of each bit
        state_next.ticks.serial_clk = run && (state_reg.act_sync
            ? state_reg.phase[2] : state_reg.phase[4]);

        // Stopped generator restarts clean from the written values
        // Values written in this very cycle count, so the first bit
        // after a start already runs at the programmed rate
        if (!run) begin
            state_next.pre_cnt = 6'h00;
            state_next.div_cnt = state_next.divisor;
            state_next.act_div = state_next.divisor;
            state_next.act_cks = state_next.ctrl[CTRL_CKS_HI:CTRL_CKS_LO];
            state_next.act_sync = state_next.ctrl[CTRL_SYNC];
            state_next.phase = 5'h00;
        end

        tx_fmt = fmt_word(tx_in_data, state_reg.fmt[2],
            state_reg.fmt[1]);

        // Two-entry skid buffer: ready is registered so a stall by
        // the receiver costs one cycle of ready, never a word
        tx_push = tx_in_valid && !state_reg.skid_valid;
        tx_pop = state_reg.tx_valid && tx_out_ready;
        if (tx_pop || !state_reg.tx_valid) begin
            if (state_reg.skid_valid) begin
                state_next.tx_data = state_reg.skid_data;
                state_next.tx_valid = 1'b1;
                state_next.skid_valid = 1'b0;
            end else begin
                state_next.tx_data = tx_fmt;
                state_next.tx_valid = tx_push;
            end
        end else if (tx_push) begin
            state_next.skid_data = tx_fmt;
            state_next.skid_valid = 1'b1;
        end
        // Ready has a flop of its own so the port comes from a register
        state_next.tx_ready = !state_next.skid_valid;

        // Receive words skip the buffer: at most one word per frame
        // receive assembled order
        state_next.rx_valid = rx_in_valid;
        if (rx_in_valid) begin
            state_next.rx_data = fmt_word(rx_in_data, state_reg.fmt[2],
                state_reg.fmt[1]);
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_n || standby) begin
            state_reg <= '0;
            state_reg.ctrl <= CTRL_RST;
            state_reg.divisor <= DIV_RST;
            state_reg.fmt <= {FMT_RST[FMT_ORDER], FMT_RST[FMT_INV],
                FMT_RST[FMT_MODE]};
            state_reg.act_div <= DIV_RST;
            state_reg.div_cnt <= DIV_RST;
            state_reg.tx_ready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign reg_rdata = state_reg.rdata;
    assign bit_tick = state_reg.ticks.bit_tick;
    assign sample_tick = state_reg.ticks.sample_tick;
    assign mid_tick = state_reg.ticks.mid_tick;
    assign serial_clk = state_reg.ticks.serial_clk;
    assign sync_mode = state_reg.act_sync;
    assign tx_in_ready = state_reg.tx_ready;
    assign tx_out_data = state_reg.tx_data;
    assign tx_out_valid = state_reg.tx_valid;
    assign rx_out_data = state_reg.rx_data;
    assign rx_out_valid = state_reg.rx_valid;

endmodule : sbrf_core

// File: testbench/sbrf_core_bench.sv
// Purpose: Self-checking bench of the rate and format block
// Assumes: Bench drives inputs by NBA after rising edges
// Notes: Divisors stay small so slow rates end quickly
`timescale 1ns/100ps
module sbrf_core_bench;
    import sbrf_pkg::*;
    // ==========================================
    // Design signals
    logic sys_clk, rst_n, standby, reg_wr, reg_rd, stall_en;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, tx_in_data, tx_out_data;
    logic [7:0] rx_in_data, rx_out_data;
    logic bit_tick, sample_tick, mid_tick, serial_clk, sync_mode;
    logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
    logic rx_in_valid, rx_out_valid;
    logic [31:0] seed = 32'h0000_0058;
    int num_errors = 0;
    int num_checks = 0;
    logic [7:0] exp_q[$];
    sbrf_core sbrf_core_i (.*);
    sbrf_line_model sbrf_line_model_i (.*);
    always #2 sys_clk = ~sys_clk;
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [7:0] shape(logic [7:0] w, logic [1:0] f);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = f[1] ? w[7-i] : w[i];
        return r ^ {8{f[0]}};
    endfunction : shape
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = 32'(reg_rdata);
    endtask : rd
    // Periodic pulses give exact counts over one whole period
    task automatic measure(output int per, output int smp, output int mid,
        output int hi);
        int guard;
        {per, smp, mid, hi, guard} = '0;
        while (bit_tick !== 1'b1 && guard < 20000) begin
            @(posedge sys_clk);
            guard++;
        end
        do begin
            @(posedge sys_clk);
            per++;
            smp += sample_tick;
            mid += mid_tick;
            hi += serial_clk;
        end while (bit_tick !== 1'b1 && per < 20000);
    endtask : measure
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // Longest run is near 45000 cycles; twice that is the limit
    initial begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [7:0] nv, w;
        logic [1:0] n, fm;
        int per, smp, mid, hi, per_e;
        sys_clk = 1'b0;
        {rst_n, standby, reg_wr, reg_rd, stall_en} = '0;
        {tx_in_valid, rx_in_valid, reg_addr} = '0;
        {reg_wdata, tx_in_data, rx_in_data} = '0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL, d);
        chk(d, 32'(CTRL_RST));
        rd(OFS_DIV, d);
        chk(d, 32'(DIV_RST));
        rd(OFS_FMT, d);
        chk(d, 32'(FMT_RST));
        // Mode select bit is kept clear in every write
        for (int i = 0; i < 3; i++) begin
            w = 8'h0C << i;
            wr(OFS_FMT, w);
            rd(OFS_FMT, d);
            chk(d, 32'((w & FMT_WMASK) | FMT_ONES));
        end
        wr(3'h5, 8'h00);
        wr(OFS_STAT, 8'h00);
        rd(3'h6, d);
        chk(d, 32'h0000_0000);
        rd(OFS_DIV, d);
        chk(d, 32'(DIV_RST));
        $display("test registers done");
        // Every prescale code, mode and peripheral rate
        for (int k = 0; k < 16; k++) begin
            n = k[3:2];
            nv = 8'(xs() % (n > 1 ? 2 : 4));
            if (k == 1) nv = 8'h00;
            wr(OFS_CTRL, 8'h00);
            wr(OFS_DIV, nv);
            wr(OFS_CTRL, {k[0], k[1], 1'b1, 3'h0, n});
            measure(per, smp, mid, hi);
            per_e = (k[0] ? 8 : 32) * (nv + 1);
            per_e = per_e * (n == 0 ? 1 : (4 ** n) * (k[1] ? 2 : 1));
            chk(per, per_e);
            chk(smp, k[0] ? 8 : 16);
            chk(mid, 1);
            chk(hi, per_e / 2);
            chk(32'(sync_mode), 32'(k[0]));
            rd(OFS_DIV, d);
            chk(d, 32'(nv));
            rd(OFS_STAT, d);
            chk(32'(d[STAT_MAXRATE]), 32'(k == 1 && nv == 0));
        end
        // Settings changed while running apply from the next reload
        wr(OFS_CTRL, 8'h00);
        wr(OFS_DIV, 8'h00);
        wr(OFS_CTRL, 8'hA0);
        measure(per, smp, mid, hi);
        chk(per, 8);
        wr(OFS_DIV, 8'h03);
        measure(per, smp, mid, hi);
        chk(per, 32);
        wr(OFS_CTRL, 8'hA1);
        measure(per, smp, mid, hi);
        chk(per, 128);
        $display("test rates done");
        // No parity is formed here, so there is no parity select to flip
        stall_en <= 1'b1;
        for (int b = 0; b < 4; b++) begin
            fm = b[1:0];
            wr(OFS_FMT, {4'h0, fm, 2'h0});
            for (int i = 0; i < 6; i++) begin
                w = 8'(xs());
                exp_q.push_back(shape(w, fm));
                tx_in_data <= w;
                tx_in_valid <= 1'b1;
                @(posedge sys_clk);
                while (tx_in_ready !== 1'b1) @(posedge sys_clk);
            end
            tx_in_valid <= 1'b0;
            w = 8'(xs());
            @(posedge sys_clk);
            rx_in_data <= w;
            rx_in_valid <= 1'b1;
            @(posedge sys_clk);
            rx_in_valid <= 1'b0;
            rx_in_data <= ~w;
            #1 chk(32'(rx_out_data), 32'(shape(w, fm)));
            chk(32'(rx_out_valid), 32'h0000_0001);
        end
        for (int g = 0; g < 500 && sbrf_line_model_i.count < 24; g++)
            @(posedge sys_clk);
        chk(sbrf_line_model_i.count, 24);
        foreach (exp_q[i]) chk(sbrf_line_model_i.words[i], exp_q[i]);
        $display("test data paths done");
        // Standby restores divisor, then format
        for (int a = 1; a < 3; a++) begin
            wr(3'(a), 8'h0C);
            @(posedge sys_clk);
            standby <= 1'b1;
            @(posedge sys_clk);
            standby <= 1'b0;
            rd(3'(a), d);
            chk(d, 32'(a == 1 ? DIV_RST : FMT_RST));
        end
        $display("test standby done");
        print_verdict();
    end
endmodule : sbrf_core_bench

// File: testbench/sbrf_core_properties.sv
// Purpose: Port checks of the rate and format block
// Assumes: Format bits mirrored from the write strobe
// Notes: Bound to every sbrf_core at the foot
`timescale 1ns/100ps
module sbrf_core_checker
    import sbrf_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic standby,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic bit_tick,
    // Data paths
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_valid,
    input wire logic tx_in_ready,
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_valid,
    input wire logic tx_out_ready,
    input wire logic [7:0] rx_in_data,
    input wire logic rx_in_valid,
    input wire logic [7:0] rx_out_data,
    input wire logic rx_out_valid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Mirror of order and invert; standby clears it too
    logic [1:0] fmt_reg;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || standby) begin
            fmt_reg <= 2'h0;
        end else if (reg_wr && reg_addr == OFS_FMT) begin
            fmt_reg <= {reg_wdata[FMT_ORDER], reg_wdata[FMT_INV]};
        end
    end
    // Reverse first, then invert
    function automatic logic [7:0] shape(logic [7:0] w, logic [1:0] f);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = f[1] ? w[7-i] : w[i];
        return r ^ {8{f[0]}};
    endfunction : shape
    // ==========================================
    // Register behaviour
    AST_FMT_ONES: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_FMT && !$past(standby)
        |-> (reg_rdata & FMT_ONES) == FMT_ONES)
        else $error("format read lost a fixed one");
    AST_FMT_RESET: assert property (
        standby ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_FMT)
        |=> reg_rdata == FMT_RST)
        else $error("format not restored by standby");
    AST_DIV_RESET: assert property (
        standby ##1 !reg_wr ##1 (reg_rd && reg_addr == OFS_DIV)
        |=> reg_rdata == DIV_RST)
        else $error("divisor not restored by standby");
    AST_TICK_PULSE: assert property (bit_tick |=> !bit_tick)
        else $error("bit tick longer than one cycle");
    // ==========================================
    // Data paths
    AST_TX_HOLD: assert property (
        tx_out_valid && !tx_out_ready && !standby
        |=> tx_out_valid && $stable(tx_out_data))
        else $error("held transmit word changed");
    AST_TX_TAKE: assert property (
        tx_in_valid && tx_in_ready && !tx_out_valid && !standby
        |=> tx_out_valid
        && tx_out_data == shape($past(tx_in_data), $past(fmt_reg)))
        else $error("transmit word wrongly formatted");
    AST_READY_FULL: assert property (
        tx_out_valid && !tx_out_ready && tx_in_valid && tx_in_ready
        && !standby |=> !tx_in_ready)
        else $error("full buffer still ready");
    AST_RX_FMT: assert property (
        rx_in_valid && !standby |=> rx_out_valid
        && rx_out_data == shape($past(rx_in_data), $past(fmt_reg)))
        else $error("receive word wrongly formatted");
    AST_RX_QUIET: assert property (!rx_in_valid |=> !rx_out_valid)
        else $error("receive valid without input");
endmodule : sbrf_core_checker

bind sbrf_core sbrf_core_checker sbrf_core_checker_i (.*);

// File: testbench/sbrf_line_model.sv
// Purpose: Far side consumer of formatted transmit words
// Assumes: Words leave on a valid and ready handshake
// Notes: Ready wanders at random while stall_en is high
`timescale 1ns/100ps
module sbrf_line_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall_en,
    // Words from the block
    input wire logic [7:0] tx_out_data,
    input wire logic tx_out_valid,
    output logic tx_out_ready
);
    // ==========================================
    // Capture store, read by the bench
    logic [7:0] words [0:63];
    int count;
    logic [15:0] lfsr;
    // Random stalls make the skid entry fill up
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            count <= 0;
            lfsr <= 16'hACE1;
            tx_out_ready <= 1'b0;
        end else begin
            lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12]};
            tx_out_ready <= !stall_en || lfsr[0];
            if (tx_out_valid && tx_out_ready) begin
                words[count[5:0]] <= tx_out_data;
                count <= count + 1;
            end
        end
    end
endmodule : sbrf_line_model
